// ### src/est_front_end.sv
// Purpose: two-wire target front end of a byte-wide serial memory
// Assumes: scl_clk is the bus clock used as a clock; rd_byte held stable
//          by the memory core while standby is low
// Notes:   sda is open drain; sda_oe high pulls the line low
`timescale 1ns/1ns
`default_nettype none
module est_front_end
  import est_pkg::*;
#(
  parameter int PROG_CNT = PROG_CYCLES
) (
  // system side
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // two-wire link
  input  wire logic                   scl_clk,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  // strap pins
  input  wire logic                   select_pin_high,
  input  wire logic                   select_pin_mid,
  input  wire logic                   select_pin_low,
  // memory core side
  input  wire logic [7:0]             rd_byte,
  output logic                        addr_load,
  output logic [WORD_ADDR_W-1:0]      word_addr,
  output logic                        area_serial,
  output logic                        serial_addr_bad,
  output logic                        rd_not_wr,
  output logic [7:0]                  wr_data,
  output logic                        wr_strobe,
  output logic                        prog_start,
  output logic                        prog_busy,
  output logic                        standby
);
  localparam int CNT_W = $clog2(PROG_CNT + 1);

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b);
    shift_in = {v[6:0], b};
  endfunction : shift_in

  ////////////////////////////////////////////////////////////////////////////
  // start and stop detectors, clocked by the data line itself
  logic start_tog;
  logic stop_tog;

  // clock sampled high at a data edge marks a condition
  always_ff @(negedge sda_in or posedge rst) begin
    if (rst) start_tog <= 1'b0;
    else if (scl_clk) start_tog <= ~start_tog;
  end

  always_ff @(posedge sda_in or posedge rst) begin
    if (rst) stop_tog <= 1'b0;
    else if (scl_clk) stop_tog <= ~stop_tog;
  end

  ////////////////////////////////////////////////////////////////////////////
  // system-domain level crossings into the link domain
  logic [2:0] sel_s1, sel_s2, sel_l1, sel_l2;
  logic       busy_l1, busy_l2;

  // strap pins settle in the system domain, then cross as quiet levels
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sel_s1 <= 3'h0;
      sel_s2 <= 3'h0;
    end else if (ce) begin
      sel_s1 <= {select_pin_high, select_pin_mid, select_pin_low};
      sel_s2 <= sel_s1;
    end
  end

  always_ff @(posedge scl_clk or posedge rst) begin
    if (rst) begin
      sel_l1  <= 3'h0;
      sel_l2  <= 3'h0;
      busy_l1 <= 1'b0;
      busy_l2 <= 1'b0;
    end else begin
      sel_l1  <= sel_s2;
      sel_l2  <= sel_l1;
      busy_l1 <= prog_busy;
      busy_l2 <= busy_l1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link state machine on rising bus clock
  est_link_state_t state, next_state;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] word_hi, next_word_hi;
  logic [7:0] word_lo, next_word_lo;
  logic [7:0] data_byte, next_data_byte;
  logic [7:0] tx_byte, next_tx_byte;
  logic       is_serial, next_is_serial;
  logic       rd_op, next_rd_op;
  logic       start_ack, next_start_ack;
  logic       stop_ack, next_stop_ack;
  logic       wr_pending, next_wr_pending;
  logic       word_tog, next_word_tog;
  logic       data_tog, next_data_tog;
  logic [7:0] full;
  logic       byte_done;
  logic       dev_match;

  assign full      = shift_in(shreg, sda_in);
  assign byte_done = (bit_cnt == LAST_BIT);
  // busy device stays silent so the controller can poll
  assign dev_match = ((full[PREFIX_MSB:PREFIX_LSB] == PREFIX_ARRAY) ||
                      (full[PREFIX_MSB:PREFIX_LSB] == PREFIX_SERIAL)) &&
                     (full[SEL_MSB:SEL_LSB] == sel_l2) && !busy_l2;

  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shreg      = shreg;
    next_word_hi    = word_hi;
    next_word_lo    = word_lo;
    next_data_byte  = data_byte;
    next_tx_byte    = tx_byte;
    next_is_serial  = is_serial;
    next_rd_op      = rd_op;
    next_start_ack  = start_ack;
    next_stop_ack   = stop_ack;
    next_wr_pending = wr_pending;
    next_word_tog   = word_tog;
    next_data_tog   = data_tog;
    if (start_tog != start_ack) begin
      // first rising edge after a start carries address bit 7
      next_start_ack  = start_tog;
      next_stop_ack   = stop_tog;
      next_state      = EST_DEV_ADDR;
      next_shreg      = {7'h00, sda_in};
      next_bit_cnt    = BIT_ONE;
      next_wr_pending = 1'b0;
    end else if (stop_tog != stop_ack) begin
      next_stop_ack = stop_tog;
      next_state    = EST_IDLE;
    end else begin
      unique case (state)
        EST_IDLE: begin
          next_bit_cnt = 3'h0;
        end
        EST_DEV_ADDR, EST_WORD_HI, EST_WORD_LO, EST_DATA_RX: begin
          next_shreg   = full;
          next_bit_cnt = 3'(bit_cnt + BIT_ONE);
          if (byte_done) begin
            if (state == EST_DEV_ADDR) begin
              next_is_serial = (full[PREFIX_MSB:PREFIX_LSB] == PREFIX_SERIAL);
              next_rd_op     = full[RW_BIT];
              next_state     = dev_match ? EST_ADDR_ACK : EST_IDLE;
            end else if (state == EST_WORD_HI) begin
              next_word_hi = full;
              next_state   = EST_HI_ACK;
            end else if (state == EST_WORD_LO) begin
              next_word_lo  = full;
              next_word_tog = ~word_tog;
              next_state    = EST_LO_ACK;
            end else begin
              next_data_byte = full;
              // serial area takes no data at all
              if (!is_serial) begin
                next_data_tog   = ~data_tog;
                next_wr_pending = 1'b1;
              end
              next_state = EST_DATA_ACK;
            end
          end
        end
        EST_ADDR_ACK: begin
          next_bit_cnt = 3'h0;
          next_tx_byte = rd_byte;
          next_state   = rd_op ? EST_TX : EST_WORD_HI;
        end
        EST_HI_ACK: begin
          next_bit_cnt = 3'h0;
          next_state   = EST_WORD_LO;
        end
        EST_LO_ACK, EST_DATA_ACK: begin
          next_bit_cnt = 3'h0;
          next_state   = EST_DATA_RX;
        end
        EST_TX: begin
          next_bit_cnt = 3'(bit_cnt + BIT_ONE);
          if (byte_done) next_state = EST_TX_ACK;
        end
        EST_TX_ACK: begin
          next_bit_cnt = 3'h0;
          next_tx_byte = rd_byte;
          // a high ninth bit ends the read; wait for stop
          next_state   = sda_in ? EST_IDLE : EST_TX;
        end
      endcase
    end
  end

  always_ff @(posedge scl_clk or posedge rst) begin
    if (rst) begin
      state      <= EST_IDLE;
      bit_cnt    <= 3'h0;
      shreg      <= 8'h00;
      word_hi    <= 8'h00;
      word_lo    <= 8'h00;
      data_byte  <= 8'h00;
      tx_byte    <= 8'h00;
      is_serial  <= 1'b0;
      rd_op      <= 1'b0;
      start_ack  <= 1'b0;
      stop_ack   <= 1'b0;
      wr_pending <= 1'b0;
      word_tog   <= 1'b0;
      data_tog   <= 1'b0;
    end else begin
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      shreg      <= next_shreg;
      word_hi    <= next_word_hi;
      word_lo    <= next_word_lo;
      data_byte  <= next_data_byte;
      tx_byte    <= next_tx_byte;
      is_serial  <= next_is_serial;
      rd_op      <= next_rd_op;
      start_ack  <= next_start_ack;
      stop_ack   <= next_stop_ack;
      wr_pending <= next_wr_pending;
      word_tog   <= next_word_tog;
      data_tog   <= next_data_tog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data line driver, updated after falling bus clock
  logic drive_low, next_drive_low;

  always_comb begin
    next_drive_low = 1'b0;
    if ((state == EST_ADDR_ACK) || (state == EST_HI_ACK) ||
        (state == EST_LO_ACK) || (state == EST_DATA_ACK))
      next_drive_low = 1'b1;
    else if (state == EST_TX)
      next_drive_low = ~tx_byte[3'(LAST_BIT - bit_cnt)];
  end

  always_ff @(negedge scl_clk or posedge rst) begin
    if (rst) drive_low <= 1'b0;
    else drive_low <= next_drive_low;
  end

  assign sda_out = 1'b0;
  assign sda_oe  = drive_low;

  ////////////////////////////////////////////////////////////////////////////
  // link events and levels into the system domain
  logic [3:0] tog_s1, tog_s2, tog_s3;
  logic [1:0] lvl_s1, lvl_s2;
  logic [3:0] evt;
  logic       engaged;

  assign engaged = (state != EST_IDLE);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tog_s1 <= 4'h0;
      tog_s2 <= 4'h0;
      tog_s3 <= 4'h0;
      lvl_s1 <= 2'h0;
      lvl_s2 <= 2'h0;
    end else if (ce) begin
      tog_s1 <= {data_tog, word_tog, stop_tog, start_tog};
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      lvl_s1 <= {wr_pending, engaged};
      lvl_s2 <= lvl_s1;
    end
  end

  // bit 0 start, 1 stop, 2 address loaded, 3 data byte
  assign evt = tog_s2 ^ tog_s3;

  ////////////////////////////////////////////////////////////////////////////
  // system side: outputs, standby and programming timer
  logic                   stop_seen, next_stop_seen;
  logic [CNT_W-1:0]       prog_cnt, next_prog_cnt;
  logic                   next_prog_busy, next_prog_start;
  logic                   next_addr_load, next_wr_strobe;
  logic [WORD_ADDR_W-1:0] next_word_addr;
  logic                   next_area_serial, next_serial_addr_bad, next_rd_not_wr;
  logic [7:0]             next_wr_data;

  always_comb begin
    next_stop_seen       = stop_seen;
    next_prog_cnt        = prog_cnt;
    next_prog_busy       = prog_busy;
    next_prog_start      = 1'b0;
    next_addr_load       = evt[2];
    next_wr_strobe       = evt[3];
    next_word_addr       = word_addr;
    next_area_serial     = area_serial;
    next_serial_addr_bad = serial_addr_bad;
    next_rd_not_wr       = rd_not_wr;
    next_wr_data         = wr_data;
    if (evt[0]) next_stop_seen = 1'b0;
    // a stop in the same cycle as a start wins
    if (evt[1]) next_stop_seen = 1'b1;
    if (evt[2]) begin
      next_area_serial = is_serial;
      next_rd_not_wr   = rd_op;
      if (is_serial) begin
        next_word_addr       = {{(WORD_ADDR_W-SERIAL_IDX_MSB-1){1'b0}},
                                word_lo[SERIAL_IDX_MSB:0]};
        next_serial_addr_bad = (word_hi[HI_KEEP_MSB:SERIAL_HI_LSB] != SERIAL_HI_CODE);
      end else begin
        next_word_addr       = {word_hi[HI_KEEP_MSB:0], word_lo};
        next_serial_addr_bad = 1'b0;
      end
    end
    if (evt[3]) next_wr_data = data_byte;
    // timer starts on a stop closing an array write
    if (prog_busy) begin
      if (prog_cnt == '0) next_prog_busy = 1'b0;
      else next_prog_cnt = CNT_W'(prog_cnt - 1'b1);
    end else if (evt[1] && lvl_s2[1]) begin
      next_prog_busy  = 1'b1;
      next_prog_start = 1'b1;
      next_prog_cnt   = CNT_W'(PROG_CNT - 1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stop_seen       <= 1'b1;
      prog_cnt        <= '0;
      prog_busy       <= 1'b0;
      prog_start      <= 1'b0;
      addr_load       <= 1'b0;
      wr_strobe       <= 1'b0;
      word_addr       <= '0;
      area_serial     <= 1'b0;
      serial_addr_bad <= 1'b0;
      rd_not_wr       <= 1'b0;
      wr_data         <= 8'h00;
    end else if (ce) begin
      stop_seen       <= next_stop_seen;
      prog_cnt        <= next_prog_cnt;
      prog_busy       <= next_prog_busy;
      prog_start      <= next_prog_start;
      addr_load       <= next_addr_load;
      wr_strobe       <= next_wr_strobe;
      word_addr       <= next_word_addr;
      area_serial     <= next_area_serial;
      serial_addr_bad <= next_serial_addr_bad;
      rd_not_wr       <= next_rd_not_wr;
      wr_data         <= next_wr_data;
    end
  end

  // standby once idle or stopped and no program cycle runs
  assign standby = ~prog_busy & (stop_seen | ~lvl_s2[0]);

endmodule : est_front_end
`default_nettype wire

// ### src/est_pkg.sv
// Purpose: constants and types for the serial memory target front end
// Assumes: system clock of 20 MHz
// Notes:   shared by the front end and its bench
package est_pkg;
  // clock and programming time
  localparam int SYS_CLK_HZ   = 20_000_000;
  localparam int PROG_TIME_MS = 5;
  // longest time, rounds down
  localparam int PROG_CYCLES  = PROG_TIME_MS * (SYS_CLK_HZ / 1000);

  // device address word layout
  localparam logic [3:0] PREFIX_ARRAY  = 4'ha;
  localparam logic [3:0] PREFIX_SERIAL = 4'hb;
  localparam int         PREFIX_MSB    = 7;
  localparam int         PREFIX_LSB    = 4;
  localparam int         SEL_MSB       = 3;
  localparam int         SEL_LSB       = 1;
  localparam int         RW_BIT        = 0;

  // word address layout
  localparam logic [1:0] SERIAL_HI_CODE = 2'h2;
  localparam int         HI_KEEP_MSB    = 3;
  localparam int         SERIAL_HI_LSB  = 2;
  localparam int         SERIAL_IDX_MSB = 4;
  localparam int         WORD_ADDR_W    = 12;

  // byte framing
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] BIT_ONE  = 3'h1;

  // link states
  typedef enum logic [3:0] {
    EST_IDLE, EST_DEV_ADDR, EST_ADDR_ACK, EST_WORD_HI, EST_HI_ACK,
    EST_WORD_LO, EST_LO_ACK, EST_DATA_RX, EST_DATA_ACK, EST_TX, EST_TX_ACK
  } est_link_state_t;
endpackage : est_pkg

// ### test/est_bus_ctl.sv
// Purpose: two-wire bus controller model
// Assumes: pull-up on data, clock stands high between frames
// Notes:   half bit is ten 30 ns link steps so the front end can sync
`timescale 1ns/1ns
`default_nettype none
module est_bus_ctl (
  // bus lines
  output logic      scl_clk,
  output logic      sda_in,
  input  wire logic sda_oe
);
  localparam int HALF = 300;
  logic drv_low = 1'b0;
  // wired line: pull-up unless a party pulls low
  assign sda_in = !(drv_low || sda_oe);
  initial scl_clk = 1'b1;
  // one clock: data set while low, sampled before fall
  task automatic bit_out(input logic b, output logic seen);
    #30 drv_low = !b;
    #(HALF - 30) scl_clk = 1'b1;
    #HALF seen = sda_in;
    scl_clk = 1'b0;
  endtask : bit_out
  task automatic start();
    #30 drv_low = 1'b0;
    #HALF scl_clk = 1'b1;
    #HALF drv_low = 1'b1;
    #HALF scl_clk = 1'b0;
  endtask : start
  task automatic stop();
    #30 drv_low = 1'b1;
    #HALF scl_clk = 1'b1;
    #HALF drv_low = 1'b0;
    #(2 * HALF);
  endtask : stop
  // msb first, ninth clock returns the line level
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_out(b[i], s);
    bit_out(1'b1, ack);
  endtask : put_byte
  task automatic get_byte(input logic nak, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_out(1'b1, b[i]);
    bit_out(nak, s);
  endtask : get_byte
endmodule : est_bus_ctl
`default_nettype wire

// ### test/est_fe_checker.sv
// Purpose: port assertions for the serial target front end
// Assumes: system-side outputs, one clock domain
// Notes:   bound into every front end instance
`timescale 1ns/1ns
`default_nettype none
module est_fe_checker #(
  parameter int PROG_CNT = 50
) (
  // system side
  input wire logic        sys_clk,
  input wire logic        rst,
  // watched outputs
  input wire logic        sda_out,
  input wire logic        addr_load,
  input wire logic [11:0] word_addr,
  input wire logic        area_serial,
  input wire logic        wr_strobe,
  input wire logic        prog_start,
  input wire logic        prog_busy,
  input wire logic        standby
);
  int   busy_cnt;
  int   next_busy_cnt;
  logic load_seen;
  logic next_load_seen;
  // busy length counter, load seen since last programming start
  always_comb begin
    next_busy_cnt  = prog_busy ? busy_cnt + 1 : 0;
    next_load_seen = prog_start ? 1'b0 : (addr_load ? 1'b1 : load_seen);
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_cnt  <= 0;
      load_seen <= 1'b0;
    end else begin
      busy_cnt  <= next_busy_cnt;
      load_seen <= next_load_seen;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_drive_low_only: assert property (sda_out == 1'b0)
    else $error("data output not low");
  a_busy_follows: assert property (prog_start |-> ##[0:1] prog_busy)
    else $error("busy missing after start");
  a_busy_length: assert property ($fell(prog_busy) |-> busy_cnt == PROG_CNT)
    else $error("busy length wrong");
  a_busy_bounded: assert property (busy_cnt <= PROG_CNT + 1)
    else $error("busy too long");
  a_busy_awake: assert property (prog_busy |-> !standby)
    else $error("standby while busy");
  a_serial_no_wr: assert property (wr_strobe |-> !area_serial)
    else $error("write strobe for serial area");
  a_serial_no_prog: assert property (prog_start |-> !area_serial)
    else $error("programming for serial area");
  a_load_first: assert property (wr_strobe |-> load_seen)
    else $error("data before address load");
  a_load_pulse: assert property (addr_load |=> !addr_load)
    else $error("address load too long");
  a_serial_index: assert property (addr_load ##1 area_serial |-> word_addr[11:5] == 7'h00)
    else $error("serial index too wide");
endmodule : est_fe_checker
`default_nettype wire
bind est_front_end est_fe_checker #(.PROG_CNT(PROG_CNT)) i_est_fe_checker (
  .sys_clk(sys_clk), .rst(rst), .sda_out(sda_out), .addr_load(addr_load),
  .word_addr(word_addr), .area_serial(area_serial), .wr_strobe(wr_strobe),
  .prog_start(prog_start), .prog_busy(prog_busy), .standby(standby));

// ### test/tb_est_front_end.sv
// Purpose: directed bench for the serial target front end
// Assumes: short programming count, strap pins 3'h5
// Notes:   expectations come from the address and word layouts
`timescale 1ns/1ns
`default_nettype none
module tb_est_front_end;
  import est_pkg::*;
  // long enough that a poll frame still meets a busy device
  localparam int         PCNT = 400;
  localparam logic [2:0] SEL  = 3'h5;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b0;
  logic        scl_clk, sda_in, sda_out, sda_oe, addr_load, area_serial;
  logic        serial_addr_bad, rd_not_wr, wr_strobe, prog_start, prog_busy, standby;
  logic [7:0]  rd_byte = 8'h3c;
  logic [7:0]  wr_data, rb;
  logic [11:0] word_addr;
  logic        ack, s;
  int          bad_count = 0;
  int          check_count = 0;
  int          n_wr = 0;
  int          n_prog = 0;
  always #25 sys_clk = !sys_clk;
  est_front_end #(.PROG_CNT(PCNT)) i_est_front_end (
    .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .scl_clk(scl_clk), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .select_pin_high(SEL[2]),
    .select_pin_mid(SEL[1]), .select_pin_low(SEL[0]), .rd_byte(rd_byte),
    .addr_load(addr_load), .word_addr(word_addr), .area_serial(area_serial),
    .serial_addr_bad(serial_addr_bad), .rd_not_wr(rd_not_wr), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .prog_start(prog_start), .prog_busy(prog_busy),
    .standby(standby));
  est_bus_ctl i_est_bus_ctl (.scl_clk(scl_clk), .sda_in(sda_in), .sda_oe(sda_oe));
  // count one-cycle pulses
  always @(posedge sys_clk) begin
    if (wr_strobe === 1'b1) n_wr++;
    if (prog_start === 1'b1) n_prog++;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic settle();
    repeat (8) @(negedge sys_clk);
  endtask : settle
  task automatic addr(input logic [7:0] a, input logic exp);
    i_est_bus_ctl.start();
    i_est_bus_ctl.put_byte(a, ack);
    check("address ack", ack, exp);
  endtask : addr
  task automatic data(input logic [7:0] d);
    i_est_bus_ctl.put_byte(d, ack);
    check("byte ack", ack, 1'b0);
  endtask : data
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // watchdog, several times the expected run
  initial begin
    #2_000_000;
    bad_count++;
    stop_test();
  end
  initial begin
    // a real edge, so the bus-clocked flops see their async reset
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    check("standby", standby, 1'b1);
    check("sda_oe", sda_oe, 1'b0);
    settle();
    // array write, top nibble of high byte ignored
    addr({PREFIX_ARRAY, SEL, 1'b0}, 1'b0);
    data(8'hf3);
    data(8'h5c);
    settle();
    check("word_addr", word_addr, 12'h35c);
    check("area", area_serial, 1'b0);
    check("dir", rd_not_wr, 1'b0);
    data(8'h96);
    settle();
    check("wr_data", wr_data, 8'h96);
    check("wr count", n_wr, 1);
    i_est_bus_ctl.stop();
    settle();
    check("busy", prog_busy, 1'b1);
    check("prog count", n_prog, 1);
    // polling while busy is refused
    addr({PREFIX_ARRAY, SEL, 1'b0}, 1'b1);
    i_est_bus_ctl.stop();
    repeat (PCNT + 10) @(negedge sys_clk);
    check("busy done", prog_busy, 1'b0);
    check("standby", standby, 1'b1);
    // each select bit and a foreign prefix
    for (int i = 0; i < 3; i++) begin
      addr({PREFIX_ARRAY, SEL ^ (3'h1 << i), 1'b0}, 1'b1);
      settle();
      check("standby", standby, 1'b1);
      i_est_bus_ctl.stop();
    end
    addr({4'h9, SEL, 1'b0}, 1'b1);
    i_est_bus_ctl.stop();
    // serial area pointer load then a write that is acknowledged but not performed
    addr({PREFIX_SERIAL, SEL, 1'b0}, 1'b0);
    data(8'h08);
    data(8'he7);
    settle();
    check("serial addr", word_addr, 12'h007);
    check("area", area_serial, 1'b1);
    check("bad", serial_addr_bad, 1'b0);
    data(8'h55);
    i_est_bus_ctl.stop();
    settle();
    check("wr count", n_wr, 1);
    check("prog count", n_prog, 1);
    addr({PREFIX_SERIAL, SEL, 1'b0}, 1'b0);
    data(8'h04);
    data(8'h00);
    settle();
    check("bad", serial_addr_bad, 1'b1);
    // abort mid-byte by a start, then read
    addr({PREFIX_ARRAY, SEL, 1'b0}, 1'b0);
    repeat (3) i_est_bus_ctl.bit_out(1'b0, s);
    addr({PREFIX_ARRAY, SEL, 1'b1}, 1'b0);
    i_est_bus_ctl.get_byte(1'b1, rb);
    check("read byte", rb, 8'h3c);
    i_est_bus_ctl.stop();
    settle();
    check("standby", standby, 1'b1);
    check("prog count", n_prog, 1);
    // recovery: start, nine clocks, start, stop
    i_est_bus_ctl.start();
    repeat (9) i_est_bus_ctl.bit_out(1'b1, s);
    i_est_bus_ctl.start();
    i_est_bus_ctl.stop();
    addr({PREFIX_ARRAY, SEL, 1'b1}, 1'b0);
    i_est_bus_ctl.get_byte(1'b1, rb);
    check("recovered read", rb, 8'h3c);
    i_est_bus_ctl.stop();
    stop_test();
  end
endmodule : tb_est_front_end
`default_nettype wire
